// ---- hw/conv_ctrl.sv ----
// Control logic for one 8-bit analog-to-digital and two digital-to-analog converters.
// Assumes a byte register bank port on the processor clock and analog macros outside.
module conv_ctrl (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic [3:0] regAddr,
    input  wire logic       regWr,
    input  wire logic       regRd,
    input  wire logic [7:0] regWdata,
    output logic      [7:0] regRdata,
    input  wire logic [7:0] adcSample,
    output logic      [2:0] adcChannel,
    output logic            adcAnalogMode,
    output logic      [1:0] adcOffsetSel,
    output logic            adcPowerOn,
    output logic            adcSampleHold,
    output logic            adcBusy,
    output logic      [7:0] dacOneCode,
    output logic      [7:0] dacTwoCode,
    output logic      [1:0] dacOneGain,
    output logic      [1:0] dacTwoGain,
    output logic            dacOneExtRef,
    output logic            dacTwoExtRef
);
    import conv_ctrl_pkg::*;

    // ==========================================================
    // Registers and internal state
    logic [7:0] dacOneCtrl_reg;
    logic [7:0] dacTwoCtrl_reg;
    logic [7:0] dacOneData_reg;
    logic [7:0] dacTwoData_reg;
    logic [7:0] chanCtrl_reg;
    logic [7:0] enOfs_reg;
    logic [7:0] result_reg;
    logic [2:0] chanLatched_reg;
    logic [1:0] ofsLatched_reg;
    logic [7:0] rdata_reg;
    logic [1:0] dacOneGain_reg;
    logic [1:0] dacTwoGain_reg;
    logic       analogMode_reg;
    logic       everEnabled_reg;

    // Handshakes from the conversion sequencer
    logic       busy;
    logic       sampleNow;
    logic       done;

    // ==========================================================
    // Address decode and access gating
    wire enabled    = enOfs_reg[BIT_ENABLE];
    wire hitEnOfs   = (regAddr == OFS_ADC_EN_OFS);
    wire hitChan    = (regAddr == OFS_ADC_CHAN_CTRL);
    wire hitResult  = (regAddr == OFS_ADC_RESULT);
    wire adcAllowed = enabled;
    wire wrEnOfs    = regWr && hitEnOfs;
    wire wrChan     = regWr && hitChan && adcAllowed;
    wire wrDacOneC  = regWr && (regAddr == OFS_DAC_ONE_CTRL);
    wire wrDacTwoC  = regWr && (regAddr == OFS_DAC_TWO_CTRL);
    wire wrDacOneD  = regWr && (regAddr == OFS_DAC_ONE_DATA);
    wire wrDacTwoD  = regWr && (regAddr == OFS_DAC_TWO_DATA);
    // Command bit one converts once; zero requests nothing
    wire startReq   = wrChan && regWdata[BIT_START];
    // Dropping the enable cancels any conversion in flight
    wire cancelConv = wrEnOfs && !regWdata[BIT_ENABLE];

    // ==========================================================
    // Converter control registers; start bit clears on completion
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            enOfs_reg      <= RST_CTRL;
            chanCtrl_reg   <= RST_CTRL;
            analogMode_reg <= 1'b0;
        end else begin
            if (wrEnOfs)
                enOfs_reg <= regWdata;
            if (wrChan) begin
                chanCtrl_reg   <= regWdata;
                analogMode_reg <= regWdata[BIT_MODE_LO] | regWdata[BIT_MODE_HI];
            end else if (done || cancelConv) begin
                chanCtrl_reg[BIT_START] <= 1'b0;
                analogMode_reg          <= chanCtrl_reg[BIT_MODE_HI]; // Start bit is the low mode bit
            end
        end
    end

    // ==========================================================
    // Settings are captured only when a start arrives
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            chanLatched_reg <= 3'h0;
            ofsLatched_reg  <= 2'h0;
        end else if (startReq) begin
            chanLatched_reg <= regWdata[2:0];
            ofsLatched_reg  <= offsetCode(enOfs_reg[4:0]);
        end
    end

    // Map offset field onto the ladder tap selection
    function automatic logic [1:0] offsetCode(input logic [4:0] f);
        if (f == OFS_CODE_35)
            return 2'h1;
        else if (f == OFS_CODE_50)
            return 2'h2;
        else
            return 2'h0;
    endfunction

    // ==========================================================
    // Conversion sequencer
    conv_timer #(
        .CYCLES (CONV_CYCLES),
        .CW     (CNT_W)
    ) u_timer (
        .clk       (clk),
        .rst       (rst),
        .start     (startReq),
        .cancel    (cancelConv),
        .busy      (busy),
        .sampleNow (sampleNow),
        .done      (done)
    );

    // Result updates only at completion, never by a write
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            result_reg      <= RST_RESULT;
            everEnabled_reg <= 1'b0;
        end else begin
            if (sampleNow)
                result_reg <= adcSample;
            if (wrEnOfs && regWdata[BIT_ENABLE])
                everEnabled_reg <= 1'b1;
        end
    end

    // ==========================================================
    // Output converter registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dacOneData_reg <= RST_DAC_DATA;
            dacTwoData_reg <= RST_DAC_DATA;
            dacOneCtrl_reg <= RST_CTRL;
            dacTwoCtrl_reg <= RST_CTRL;
            dacOneGain_reg <= GAIN_1X;
            dacTwoGain_reg <= GAIN_1X;
        end else begin
            if (wrDacOneD)
                dacOneData_reg <= regWdata;
            if (wrDacTwoD)
                dacTwoData_reg <= regWdata;
            if (wrDacOneC) begin
                dacOneCtrl_reg <= regWdata;
                dacOneGain_reg <= gainCode(regWdata[1:0]);
            end
            if (wrDacTwoC) begin
                dacTwoCtrl_reg <= regWdata;
                dacTwoGain_reg <= gainCode(regWdata[1:0]);
            end
        end
    end

    // Gain code 11 folds onto 1X
    function automatic logic [1:0] gainCode(input logic [1:0] g);
        return (g == 2'h3) ? GAIN_1X : g;
    endfunction

    // ==========================================================
    // Read path; ADC channel and result registers read zero while disabled
    wire [7:0] resultView = everEnabled_reg ? result_reg : 8'h00;
    wire [7:0] rdMux =
        (regAddr == OFS_DAC_ONE_CTRL) ? dacOneCtrl_reg :
        (regAddr == OFS_DAC_TWO_CTRL) ? dacTwoCtrl_reg :
        (regAddr == OFS_DAC_ONE_DATA) ? dacOneData_reg :
        (regAddr == OFS_DAC_TWO_DATA) ? dacTwoData_reg :
        hitEnOfs                      ? enOfs_reg      :
        (hitChan && adcAllowed)       ? chanCtrl_reg   :
        (hitResult && adcAllowed)     ? resultView     :
        8'h00;

    // Registered read data
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            rdata_reg <= 8'h00;
        else if (regRd)
            rdata_reg <= rdMux;
    end

    // ==========================================================
    // Outputs to the analog macros
    assign regRdata      = rdata_reg;
    assign adcChannel    = chanLatched_reg;
    assign adcAnalogMode = analogMode_reg;
    assign adcOffsetSel  = ofsLatched_reg;
    assign adcPowerOn    = enabled;
    assign adcSampleHold = busy;
    assign adcBusy       = busy;
    assign dacOneCode    = dacOneData_reg;
    assign dacTwoCode    = dacTwoData_reg;
    assign dacOneGain    = dacOneGain_reg;
    assign dacTwoGain    = dacTwoGain_reg;
    assign dacOneExtRef  = dacOneCtrl_reg[BIT_REF_SEL];
    assign dacTwoExtRef  = dacTwoCtrl_reg[BIT_REF_SEL];
endmodule

// ---- hw/conv_ctrl_pkg.sv ----
// Constants shared by the converter control block and its timing module.
// Assumes a single 250 MHz system clock and a byte-wide register bank port.
package conv_ctrl_pkg;
    // ==========================================================
    // Register bank offsets
    localparam logic [3:0] OFS_DAC_ONE_CTRL  = 4'h4;
    localparam logic [3:0] OFS_DAC_TWO_CTRL  = 4'h5;
    localparam logic [3:0] OFS_DAC_ONE_DATA  = 4'h6;
    localparam logic [3:0] OFS_DAC_TWO_DATA  = 4'h7;
    localparam logic [3:0] OFS_ADC_CHAN_CTRL = 4'h8;
    localparam logic [3:0] OFS_ADC_EN_OFS    = 4'h9;
    localparam logic [3:0] OFS_ADC_RESULT    = 4'ha;
    // ==========================================================
    // Field positions
    localparam int BIT_ENABLE    = 7;
    localparam int BIT_START     = 3;
    localparam int BIT_MODE_LO   = 3;
    localparam int BIT_MODE_HI   = 4;
    localparam int BIT_REF_SEL   = 2;
    // ==========================================================
    // Reset values
    localparam logic [7:0] RST_DAC_DATA = 8'h80;
    localparam logic [7:0] RST_CTRL     = 8'h00;
    localparam logic [7:0] RST_RESULT   = 8'h00;
    // ==========================================================
    // Offset codes in bits 0..4 of the enable/offset register
    localparam logic [4:0] OFS_CODE_NONE = 5'h00;
    localparam logic [4:0] OFS_CODE_35   = 5'h01;
    localparam logic [4:0] OFS_CODE_50   = 5'h02;
    // Gain codes
    localparam logic [1:0] GAIN_1X       = 2'h0;
    localparam logic [1:0] GAIN_HALF     = 2'h1;
    localparam logic [1:0] GAIN_QUARTER  = 2'h2;
    // ==========================================================
    // Conversion timing
    localparam int CONV_CYCLES = 35;
    localparam int CNT_W       = 6;
endpackage

// ---- hw/conv_timer.sv ----
// Conversion sequencer: counts a fixed number of cycles per conversion.
// Assumes start and abort come from logic on the same clock.
module conv_timer #(
    parameter int CYCLES = conv_ctrl_pkg::CONV_CYCLES,
    parameter int CW     = conv_ctrl_pkg::CNT_W
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic start,
    input  wire logic cancel,
    output logic      busy,
    output logic      sampleNow,
    output logic      done
);
    import conv_ctrl_pkg::*;
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);
    logic [CW-1:0] cnt_reg;
    logic          busy_reg;

    // ==========================================================
    // Counter: a start restarts from zero even mid conversion
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_reg  <= '0;
            busy_reg <= 1'b0;
        end else if (start) begin
            cnt_reg  <= '0;
            busy_reg <= 1'b1;
        end else if (cancel || done) begin
            busy_reg <= 1'b0;
        end else if (busy_reg) begin
            cnt_reg <= cnt_reg + CW'(1);
        end
    end

    // Done after CYCLES busy cycles; sample at the final cycle
    assign busy      = busy_reg;
    assign done      = busy_reg && !start && !cancel && (cnt_reg == LAST);
    assign sampleNow = done;
endmodule

// ---- tb/conv_ctrl_asserts.sv ----
// Concurrent checks on the converter control block ports.
// Assumes binding onto conv_ctrl, one clock and an async active-high reset.
module conv_ctrl_asserts (
    input wire logic       clk,
    input wire logic       rst,
    input wire logic [3:0] regAddr,
    input wire logic       regWr,
    input wire logic [7:0] regWdata,
    input wire logic [2:0] adcChannel,
    input wire logic       adcBusy,
    input wire logic       adcPowerOn,
    input wire logic [7:0] dacOneCode,
    input wire logic [7:0] dacTwoCode,
    input wire logic [1:0] dacOneGain,
    input wire logic       dacTwoExtRef
);
    import conv_ctrl_pkg::*;
    // ==========================================================
    // Write decodes and a count of busy cycles since the last start
    logic       startWr;
    logic       oneWr;
    logic [7:0] busyCnt;
    assign startWr = regWr && regAddr == OFS_ADC_CHAN_CTRL && regWdata[BIT_START] && adcPowerOn;
    assign oneWr   = regWr && regAddr == OFS_DAC_ONE_DATA;
    always_ff @(posedge clk or posedge rst) begin
        if (rst || startWr || !adcBusy) busyCnt <= 8'h00;
        else busyCnt <= busyCnt + 8'h01;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // ==========================================================
    // Properties
    property p_startBusy; startWr |=> adcBusy && adcChannel == $past(regWdata[2:0]); endproperty
    property p_offBlock; !adcPowerOn |-> !adcBusy; endproperty
    property p_busyMax; busyCnt <= 8'h23; endproperty
    property p_busyLen; $fell(adcBusy) && adcPowerOn |-> busyCnt == 8'h23; endproperty
    property p_dacOne; oneWr |=> dacOneCode == $past(regWdata); endproperty
    property p_dacTwo;
        regWr && regAddr == OFS_DAC_TWO_DATA |=> dacTwoCode == $past(regWdata);
    endproperty
    property p_dacHold; $changed(dacOneCode) |-> $past(oneWr); endproperty
    property p_chanHold; $changed(adcChannel) |-> $past(startWr); endproperty
    property p_gain;
        regWr && regAddr == OFS_DAC_ONE_CTRL |=>
            dacOneGain == (($past(regWdata[1:0]) == 2'h3) ? GAIN_1X : $past(regWdata[1:0]));
    endproperty
    property p_extRef;
        regWr && regAddr == OFS_DAC_TWO_CTRL |=> dacTwoExtRef == $past(regWdata[BIT_REF_SEL]);
    endproperty
    a_startBusy: assert property (p_startBusy) else $error("start did not latch");
    a_offBlock: assert property (p_offBlock) else $error("busy while disabled");
    a_busyMax: assert property (p_busyMax) else $error("conversion too long");
    a_busyLen: assert property (p_busyLen) else $error("conversion length off");
    a_dacOne: assert property (p_dacOne) else $error("first code not set");
    a_dacTwo: assert property (p_dacTwo) else $error("second code not set");
    a_dacHold: assert property (p_dacHold) else $error("code moved unwritten");
    a_chanHold: assert property (p_chanHold) else $error("channel moved");
    a_gain: assert property (p_gain) else $error("gain mismatch");
    a_extRef: assert property (p_extRef) else $error("reference select mismatch");
    c_start: cover property (startWr);
    c_done: cover property ($fell(adcBusy) && adcPowerOn);
    c_gainThree: cover property (regWr && regAddr == OFS_DAC_ONE_CTRL && regWdata[1:0] == 2'h3);
endmodule

// ---- tb/conv_ctrl_tb.sv ----
// Self-checking bench for the converter control block.
// Assumes the package and design are compiled first; drives the register port directly.
module conv_ctrl_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import conv_ctrl_pkg::*;
    // ==========================================================
    // Signals, clock and design
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic [3:0] regAddr = 4'h0;
    logic       regWr = 1'b0;
    logic       regRd = 1'b0;
    logic [7:0] regWdata = 8'h00;
    logic [7:0] adcSample = 8'h00;
    logic [7:0] regRdata, dacOneCode, dacTwoCode, rdVal;
    logic [2:0] adcChannel;
    logic [1:0] adcOffsetSel, dacOneGain, dacTwoGain, ge;
    logic       adcAnalogMode, adcPowerOn, adcSampleHold, adcBusy, dacOneExtRef, dacTwoExtRef;
    int         err_count = 0;
    int         tests_run = 0;
    int         cycles = 0;
    int         n;
    always #2 clk = ~clk;
    conv_ctrl u_dut (.clk, .rst, .regAddr, .regWr, .regRd, .regWdata, .regRdata, .adcSample,
        .adcChannel, .adcAnalogMode, .adcOffsetSel, .adcPowerOn, .adcSampleHold, .adcBusy,
        .dacOneCode, .dacTwoCode, .dacOneGain, .dacTwoGain, .dacOneExtRef, .dacTwoExtRef);
    // ==========================================================
    // Register port tasks and comparison
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk) #1;
        regAddr = a;
        regWdata = d;
        regWr = 1'b1;
        @(posedge clk) #1;
        regWr = 1'b0;
    endtask
    task automatic rdChk(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk) #1;
        regAddr = a;
        regRd = 1'b1;
        @(posedge clk) #1;
        regRd = 1'b0;
        chk(regRdata, exp);
    endtask
    // Counts busy cycles, bounded so a stuck flag cannot hang the run
    task automatic waitBusy;
        n = 0;
        while (adcBusy === 1'b1 && n < 100) begin
            n++;
            @(posedge clk) #1;
        end
    endtask
    task automatic end_of_test;
        $display("Checks run %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // Cuts a hang short
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            err_count++;
            end_of_test;
        end
    end
    // ==========================================================
    // Test sequence
    initial begin
        repeat (8) @(posedge clk);
        #1 rst = 1'b0;
        rdChk(OFS_DAC_ONE_DATA, RST_DAC_DATA);
        rdChk(OFS_DAC_TWO_DATA, RST_DAC_DATA);
        rdChk(OFS_ADC_RESULT, 8'h00);
        wr(OFS_ADC_CHAN_CTRL, 8'h0b);
        chk({7'h00, adcBusy}, 8'h00);
        rdChk(OFS_ADC_CHAN_CTRL, 8'h00);
        // Gain codes and reference select of both output converters
        for (int g = 0; g < 4; g++) begin
            ge = (g == 3) ? 2'h0 : 2'(g);
            wr(OFS_DAC_ONE_CTRL, 8'(g * 5));
            wr(OFS_DAC_TWO_CTRL, 8'((g * 5) ^ 4));
            chk({2'h0, dacOneExtRef, dacTwoExtRef, dacOneGain, dacTwoGain},
                {2'h0, 1'(g % 2), 1'((g + 1) % 2), ge, ge});
            rdChk(OFS_DAC_TWO_CTRL, 8'((g * 5) ^ 4));
        end
        wr(OFS_DAC_ONE_DATA, 8'h3c);
        wr(OFS_DAC_TWO_DATA, 8'hc5);
        chk(dacOneCode, 8'h3c);
        chk(dacTwoCode, 8'hc5);
        rdChk(OFS_DAC_TWO_DATA, 8'hc5);
        // Every channel, one conversion each, with offset codes 0 to 3 twice over
        for (int c = 0; c < 8; c++) begin
            wr(OFS_ADC_EN_OFS, 8'h80 | 8'(c % 4));
            adcSample = 8'(c * 17 + 3);
            wr(OFS_ADC_CHAN_CTRL, 8'h08 | 8'(c));
            ge = (c % 4 == 3) ? 2'h0 : 2'(c % 4);
            chk({adcAnalogMode, adcOffsetSel, 2'h0, adcChannel}, {1'b1, ge, 2'h0, 3'(c)});
            chk({5'h00, adcPowerOn, adcSampleHold, adcBusy}, 8'h07);
            waitBusy;
            chk(8'(n), 8'h23);
            rdChk(OFS_ADC_CHAN_CTRL, 8'(c));
            rdChk(OFS_ADC_RESULT, 8'(c * 17 + 3));
        end
        // Restart mid-conversion, then a write to the result register
        wr(OFS_ADC_CHAN_CTRL, 8'h09);
        wr(OFS_ADC_EN_OFS, 8'h82);
        chk({6'h00, adcOffsetSel}, 8'h00);
        repeat (8) @(posedge clk);
        #1 adcSample = 8'h5a;
        wr(OFS_ADC_CHAN_CTRL, 8'h0d);
        chk({3'h0, adcOffsetSel, adcChannel}, 8'h15);
        waitBusy;
        chk(8'(n), 8'h23);
        wr(OFS_ADC_RESULT, 8'hff);
        rdChk(OFS_ADC_RESULT, 8'h5a);
        // Disabling cancels a running conversion and blocks result reads
        wr(OFS_ADC_CHAN_CTRL, 8'h0a);
        wr(OFS_ADC_EN_OFS, 8'h00);
        chk({5'h00, adcPowerOn, adcSampleHold, adcBusy}, 8'h00);
        rdChk(OFS_ADC_RESULT, 8'h00);
        end_of_test;
    end
endmodule
bind conv_ctrl conv_ctrl_asserts u_chk (.clk, .rst, .regAddr, .regWr, .regWdata, .adcChannel,
    .adcBusy, .adcPowerOn, .dacOneCode, .dacTwoCode, .dacOneGain, .dacTwoExtRef);
